// ==== include/upmd_pkg.sv ====
// Constants, mode encodings and packed carriers for the port mode decoder.
// Assumes a single 125 MHz core clock and an AXI4-Lite register bus.
package upmd_pkg;
    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] UPMD_ADDR_CTRL = 8'h00;
    localparam logic [7:0] UPMD_ADDR_STAT = 8'h04;
    localparam logic [7:0] UPMD_ADDR_IRQ = 8'h08;
    localparam logic [7:0] UPMD_ADDR_MASK = 8'h0C;
    // CTRL fields
    localparam int UPMD_CTRL_SEL_LO = 0;
    localparam int UPMD_CTRL_SEL_HI = 1;
    localparam int UPMD_CTRL_EN = 2;
    localparam logic [31:0] UPMD_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] UPMD_MASK_RST = 32'h0000_0000;
    // IRQ event bits
    localparam int UPMD_EV_MODE = 0;
    localparam int UPMD_EV_LOAD_ON = 1;
    localparam int UPMD_EV_LOAD_OFF = 2;
    localparam int UPMD_EV_FAULT = 3;
    localparam int UPMD_EV_W = 4;
    localparam logic [1:0] UPMD_RESP_OK = 2'h0;
    localparam logic [1:0] UPMD_RESP_ERR = 2'h2;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int UPMD_CLK_MHZ = 125;
    localparam int UPMD_LOAD_ON_MS = 210;
    localparam int UPMD_LOAD_OFF_MS = 3000;
    localparam int UPMD_DISCH_US = 10;
    localparam int UPMD_LOAD_ON_CYC = UPMD_LOAD_ON_MS * 1000 * UPMD_CLK_MHZ;
    localparam int UPMD_LOAD_OFF_CYC = UPMD_LOAD_OFF_MS * 1000 * UPMD_CLK_MHZ;
    localparam int UPMD_DISCH_CYC = UPMD_DISCH_US * UPMD_CLK_MHZ;
    // ==========================================================
    // Modes
    // ==========================================================
    typedef enum logic [3:0] {
        UPMD_CLIENT = 4'h1,
        UPMD_SDP = 4'h2,
        UPMD_SDP_ALT = 4'h4,
        UPMD_CDP = 4'h8
    } upmd_mode_t;
    // Fault sources, packed together
    typedef struct packed {
        logic overtemp_shutdown;
        logic out_fault;
        logic dplus_input;
        logic dminus_input;
        logic overvoltage_protect;
        logic other;
    } upmd_fault_t;
    // Mode-dependent outputs
    typedef struct packed {
        logic power_on;
        logic high_current_limit;
        logic low_current_limit;
        logic cable_comp;
        logic load_current_monitor;
        logic fault_en;
        logic load_det_en;
        logic cdp_sig;
    } upmd_outs_t;
endpackage

// ==== rtl/upmd_timer.sv ====
// Up-counting qualifier: output rises after input held for LIMIT cycles.
// Assumes a synchronous level input; a lapse of the input restarts the count.
`timescale 1ns/100ps
module upmd_timer import upmd_pkg::*; #(
    parameter int LIMIT = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_cond,
    output logic o_done
);
    // ==========================================================
    // Counter
    // ==========================================================
    logic [31:0] cnt_q; // Cycles the condition has held
    // Saturating count; drops to zero the moment the condition lapses
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 32'h0;
        end else if (i_ce) begin
            if (!i_cond) begin
                cnt_q <= 32'h0;
            end else if (cnt_q < 32'(LIMIT)) begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
    assign o_done = (cnt_q >= 32'(LIMIT));
endmodule

// ==== rtl/upmd_axil.sv ====
// AXI4-Lite slave for the four decoder registers.
// Assumes one outstanding write and one read; answers a read one cycle after taking, a write two.
`timescale 1ns/100ps
module upmd_axil import upmd_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] i_stat,
    input wire logic [UPMD_EV_W-1:0] i_events,
    output logic [31:0] o_ctrl,
    output logic [UPMD_EV_W-1:0] o_mask,
    output logic o_irq
);
    // ==========================================================
    // Write channel
    // ==========================================================
    logic aw_have_q, w_have_q; // Captured halves of a write
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] ctrl_q, mask_q;
    logic [UPMD_EV_W-1:0] irq_q;
    logic wr_go, rd_go, irq_rd;
    assign o_awready = !aw_have_q && !o_bvalid;
    assign o_wready = !w_have_q && !o_bvalid;
    assign wr_go = aw_have_q && w_have_q && !o_bvalid;
    // Address and data accepted in either order, response after both
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= UPMD_RESP_OK;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_q == UPMD_ADDR_CTRL || awaddr_q == UPMD_ADDR_MASK) ?
                    UPMD_RESP_OK : UPMD_RESP_ERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end
    // Byte-lane writes into control and mask
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= UPMD_CTRL_RST;
            mask_q <= UPMD_MASK_RST;
        end else if (i_ce && wr_go) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_q[b] && awaddr_q == UPMD_ADDR_CTRL) begin
                    ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                end
                if (wstrb_q[b] && awaddr_q == UPMD_ADDR_MASK) begin
                    mask_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                end
            end
        end
    end
    // ==========================================================
    // Read channel and sticky events
    // ==========================================================
    assign o_arready = !o_rvalid;
    assign rd_go = i_arvalid && o_arready;
    assign irq_rd = rd_go && (i_araddr == UPMD_ADDR_IRQ);
    // Read-to-clear; a new event in the clearing cycle still lands
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_q <= '0;
        end else if (i_ce) begin
            irq_q <= (irq_rd ? '0 : irq_q) | i_events;
        end
    end
    // Registered read data, unmapped address gives SLVERR and zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= UPMD_RESP_OK;
        end else if (i_ce) begin
            if (rd_go) begin
                o_rvalid <= 1'b1;
                o_rresp <= UPMD_RESP_OK;
                unique case (i_araddr)
                    UPMD_ADDR_CTRL: o_rdata <= ctrl_q;
                    UPMD_ADDR_STAT: o_rdata <= i_stat;
                    UPMD_ADDR_IRQ: o_rdata <= {{(32-UPMD_EV_W){1'b0}}, irq_q};
                    UPMD_ADDR_MASK: o_rdata <= mask_q;
                    default: begin
                        o_rdata <= 32'h0;
                        o_rresp <= UPMD_RESP_ERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
    assign o_ctrl = ctrl_q;
    assign o_mask = mask_q[UPMD_EV_W-1:0];
    assign o_irq = |(irq_q & mask_q[UPMD_EV_W-1:0]);
endmodule

// ==== rtl/upmd_top.sv ====
// Mode decoder of a USB charging-port switch, with register access.
// Assumes all pin inputs synchronous to I_CORE_CLK; analog parts lie outside.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module upmd_top import upmd_pkg::*; #(
    parameter int LOAD_ON_CYC = UPMD_LOAD_ON_CYC,
    parameter int LOAD_OFF_CYC = UPMD_LOAD_OFF_CYC,
    parameter int DISCH_CYC = UPMD_DISCH_CYC
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_LOAD_ABOVE,
    input wire logic I_LOAD_BELOW,
    input wire logic [5:0] I_FAULTS,
    output logic O_POWER_ON,
    output logic O_HIGH_CURRENT_LIMIT,
    output logic O_LOW_CURRENT_LIMIT,
    output logic O_CABLE_COMP,
    output logic O_LOAD_CURRENT_MONITOR,
    output logic O_DATA_SW_ON,
    output logic O_DISCHARGE,
    output logic O_CDP_SIG,
    output logic O_LOAD_DETECT,
    output logic O_FAULT_B,
    output logic O_IRQ
);
    // ==========================================================
    // Register bus
    // ==========================================================
    logic [31:0] ctrl; // Software control word
    logic [31:0] stat; // Live status word
    logic [UPMD_EV_W-1:0] events; // One-cycle event pulses
    upmd_axil u_axil (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_ce(I_CE),
        .i_awaddr(I_AWADDR),
        .i_awvalid(I_AWVALID),
        .o_awready(O_AWREADY),
        .i_wdata(I_WDATA),
        .i_wstrb(I_WSTRB),
        .i_wvalid(I_WVALID),
        .o_wready(O_WREADY),
        .o_bresp(O_BRESP),
        .o_bvalid(O_BVALID),
        .i_bready(I_BREADY),
        .i_araddr(I_ARADDR),
        .i_arvalid(I_ARVALID),
        .o_arready(O_ARREADY),
        .o_rdata(O_RDATA),
        .o_rresp(O_RRESP),
        .o_rvalid(O_RVALID),
        .i_rready(I_RREADY),
        .i_stat(stat),
        .i_events(events),
        .o_ctrl(ctrl),
        .o_mask(),
        .o_irq(O_IRQ)
    );
    // ==========================================================
    // Mode decode
    // ==========================================================
    logic mode_select_hi, mode_select_lo, enable;
    upmd_mode_t mode_d, mode_q;
    assign mode_select_hi = ctrl[UPMD_CTRL_SEL_HI];
    assign mode_select_lo = ctrl[UPMD_CTRL_SEL_LO];
    assign enable = ctrl[UPMD_CTRL_EN];
    // CTRL select bits to one-hot mode
    always_comb begin
        unique case ({mode_select_hi, mode_select_lo})
            2'b00: mode_d = UPMD_CLIENT;
            2'b01: mode_d = UPMD_SDP;
            2'b10: mode_d = UPMD_SDP_ALT;
            2'b11: mode_d = UPMD_CDP;
        endcase
    end
    logic mode_chg; // Commanded mode differs from the held one
    logic ppm_swap; // Change between the two PPM modes
    logic disch_start;
    assign mode_chg = (mode_d != mode_q);
    assign ppm_swap = (mode_q == UPMD_SDP_ALT && mode_d == UPMD_CDP) ||
        (mode_q == UPMD_CDP && mode_d == UPMD_SDP_ALT);
    assign disch_start = mode_chg && !ppm_swap;
    // Follow the select inputs each cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode_q <= UPMD_CLIENT;
        end else if (I_CE) begin
            mode_q <= mode_d;
        end
    end
    // ==========================================================
    // Output rail discharge
    // ==========================================================
    logic [15:0] disch_q; // Remaining discharge cycles
    // A fresh change other than a PPM swap during a discharge restarts it
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            disch_q <= 16'h0;
        end else if (I_CE) begin
            if (disch_start) begin
                disch_q <= 16'(DISCH_CYC);
            end else if (disch_q != 16'h0) begin
                disch_q <= disch_q - 16'h1;
            end
        end
    end
    logic discharging;
    assign discharging = (disch_q != 16'h0);
    // ==========================================================
    // Mode outputs
    // ==========================================================
    upmd_outs_t outs;
    // Client leaves power off yet stays active without an external rail
    always_comb begin
        outs = '0;
        unique case (mode_q)
            UPMD_CLIENT: outs.power_on = 1'b0;
            UPMD_SDP, UPMD_SDP_ALT: begin
                outs.power_on = 1'b1;
                outs.low_current_limit = 1'b1;
                outs.cable_comp = 1'b1;
                outs.load_current_monitor = 1'b1;
                outs.fault_en = 1'b1;
            end
            UPMD_CDP: begin
                outs.power_on = 1'b1;
                outs.high_current_limit = 1'b1;
                outs.cable_comp = 1'b1;
                outs.load_current_monitor = 1'b1;
                outs.fault_en = 1'b1;
                outs.load_det_en = 1'b1;
                outs.cdp_sig = 1'b1;
            end
        endcase
    end
    // Fault qualification; alternate port ignores the miscellaneous source
    upmd_fault_t flt;
    logic fault_hit;
    assign flt = upmd_fault_t'(I_FAULTS);
    always_comb begin
        if (mode_q == UPMD_SDP_ALT) begin
            fault_hit = flt.overtemp_shutdown | flt.out_fault | flt.dplus_input |
                flt.dminus_input | flt.overvoltage_protect;
        end else begin
            fault_hit = |I_FAULTS;
        end
    end
    logic sw_on; // Data switches, all modes here pass data
    assign sw_on = enable && !discharging;
    // ==========================================================
    // Load detect
    // ==========================================================
    logic on_done, off_done, load_q;
    upmd_timer #(.LIMIT(LOAD_ON_CYC)) u_on (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_ce(I_CE),
        .i_cond(I_LOAD_ABOVE && outs.load_det_en),
        .o_done(on_done)
    );
    upmd_timer #(.LIMIT(LOAD_OFF_CYC)) u_off (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_ce(I_CE),
        .i_cond(I_LOAD_BELOW || !outs.load_det_en),
        .o_done(off_done)
    );
    // Status flag with hysteresis; leaving CDP drops it at once
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            load_q <= 1'b0;
        end else if (I_CE) begin
            if (!outs.load_det_en) begin
                load_q <= 1'b0;
            end else if (on_done) begin
                load_q <= 1'b1;
            end else if (off_done) begin
                load_q <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Registered outputs and events
    // ==========================================================
    logic load_p_q, fault_p_q;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_POWER_ON <= 1'b0;
            O_HIGH_CURRENT_LIMIT <= 1'b0;
            O_LOW_CURRENT_LIMIT <= 1'b0;
            O_CABLE_COMP <= 1'b0;
            O_LOAD_CURRENT_MONITOR <= 1'b0;
            O_DATA_SW_ON <= 1'b0;
            O_DISCHARGE <= 1'b0;
            O_CDP_SIG <= 1'b0;
            O_FAULT_B <= 1'b1;
            load_p_q <= 1'b0;
            fault_p_q <= 1'b0;
        end else if (I_CE) begin
            O_POWER_ON <= outs.power_on;
            O_HIGH_CURRENT_LIMIT <= outs.high_current_limit;
            O_LOW_CURRENT_LIMIT <= outs.low_current_limit;
            O_CABLE_COMP <= outs.cable_comp;
            O_LOAD_CURRENT_MONITOR <= outs.load_current_monitor;
            O_DATA_SW_ON <= sw_on;
            O_DISCHARGE <= discharging;
            O_CDP_SIG <= outs.cdp_sig && sw_on;
            O_FAULT_B <= !(fault_hit && outs.fault_en);
            load_p_q <= load_q;
            fault_p_q <= fault_hit && outs.fault_en;
        end
    end
    assign O_LOAD_DETECT = load_p_q;
    assign events = {fault_hit && outs.fault_en && !fault_p_q && I_CE,
        !load_q && load_p_q && I_CE, load_q && !load_p_q && I_CE, mode_chg && I_CE};
    assign stat = {20'h0, O_FAULT_B, load_q, discharging, sw_on, mode_q, 2'h0,
        mode_select_hi, mode_select_lo};
    // ==========================================================
    // Checks
    // ==========================================================
    a_mode_decode: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE |=> (mode_q == UPMD_CDP) == $past(mode_select_hi && mode_select_lo))
        else $error("mode decode wrong");
    a_client_power: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && mode_q == UPMD_CLIENT |=> !O_POWER_ON)
        else $error("power on in client mode");
    a_ppm_nodisch: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && ppm_swap && !discharging |=> !discharging)
        else $error("discharge on ppm swap");
    a_disch_start: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && disch_start |=> discharging ##1 !O_DATA_SW_ON)
        else $error("discharge not started");
    a_sw_enable: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && !enable |=> !O_DATA_SW_ON)
        else $error("switch on without enable");
    a_sw_disch: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && discharging |=> !O_DATA_SW_ON)
        else $error("switch on in discharge");
    a_cdp_sw: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && mode_q == UPMD_CDP && enable && !discharging |=> O_DATA_SW_ON && O_CDP_SIG)
        else $error("cdp switch off");
    a_alt_fault: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && mode_q == UPMD_SDP_ALT && I_FAULTS == 6'h01 |=> O_FAULT_B)
        else $error("alt mode tripped on excluded fault");
    a_load_drop: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_CE && !outs.load_det_en |=> !load_q)
        else $error("load detect outside cdp");
endmodule

// ==== test/upmd_port_model.sv ====
// Far-side model: load current comparators and fault sources of the port.
// Assumes the bench picks a load level and a fault pattern at clock edges.
`timescale 1ns/100ps
module upmd_port_model (
    input wire logic i_clk,
    input wire logic [1:0] i_load,
    input wire logic [5:0] i_fault,
    output logic o_load_above,
    output logic o_load_below,
    output logic [5:0] o_faults
);
    // ==========================================================
    // Level 2 is a heavy load, 0 a light one, 1 sits in between
    // ==========================================================
    // Defined from time zero, so the decoder never sees unknowns
    initial begin
        o_load_above = 1'b0;
        o_load_below = 1'b1;
        o_faults = 6'h00;
    end
    // Comparators and fault pins settle once a cycle
    always @(posedge i_clk) begin
        o_load_above <= (i_load == 2'h2);
        o_load_below <= (i_load == 2'h0);
        o_faults <= i_fault;
    end
endmodule

// ==== test/testbench.sv ====
// Bench for the port mode decoder: AXI4-Lite tasks and mode sequences.
// Assumes the port model drives the load and fault pins.
`timescale 1ns/100ps
module testbench import upmd_pkg::*; ();
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] lvl = 2'h0;
    logic [5:0] flt = 6'h00, faults;
    logic awready, wready, bvalid, arready, rvalid, above, below;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pw, hi, lo, cc, mon, sw, dis, cdp, ld, fault_b, irq;
    logic [2:0] seq [0:8] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h6, 3'h7, 3'h5, 3'h4, 3'h7};
    logic [1:0] pm;
    int n_mismatch = 0, samples_checked = 0;
    wire [31:0] outs_now = {24'h0, pw, hi, lo, cc, mon, sw, dis, cdp};
    always #4 clk = ~clk;
    upmd_port_model i_upmd_port_model (.i_clk(clk), .i_load(lvl), .i_fault(flt),
        .o_load_above(above), .o_load_below(below), .o_faults(faults));
    // Short counts keep the run brief
    upmd_top #(.LOAD_ON_CYC(20), .LOAD_OFF_CYC(30), .DISCH_CYC(5)) i_upmd_top (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_LOAD_ABOVE(above), .I_LOAD_BELOW(below), .I_FAULTS(faults),
        .O_POWER_ON(pw), .O_HIGH_CURRENT_LIMIT(hi), .O_LOW_CURRENT_LIMIT(lo),
        .O_CABLE_COMP(cc), .O_LOAD_CURRENT_MONITOR(mon), .O_DATA_SW_ON(sw),
        .O_DISCHARGE(dis), .O_CDP_SIG(cdp), .O_LOAD_DETECT(ld), .O_FAULT_B(fault_b),
        .O_IRQ(irq));
    // ==========================================================
    // Reporting
    // ==========================================================
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // A silent slave must not hang the run
    task automatic tmo(input int n);
        if (n > 200) begin
            n_mismatch++;
            $display("[ERR] bus answer exp 1 got 0");
            give_verdict();
        end
    endtask
    // ==========================================================
    // Bus tasks: readies are sampled mid-cycle, where they are settled
    // ==========================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        logic [1:0] r;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta === 1'b1) awvalid <= 1'b0;
            if (tw === 1'b1) wvalid <= 1'b0;
            n++;
            tmo(n);
        end while (tb !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ta, tr;
        logic [1:0] r;
        logic [31:0] d;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta === 1'b1) arvalid <= 1'b0;
            n++;
            tmo(n);
        end while (tr !== 1'b1);
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", e, d);
    endtask
    // Expected pin levels of a settled mode
    function automatic logic [31:0] mode_outs(input logic [1:0] m, input logic en);
        return {24'h0, m != 2'h0, m == 2'h3, m == 2'h1 || m == 2'h2, m != 2'h0,
            m != 2'h0, en, 1'b0, m == 2'h3 && en};
    endfunction
    // Mode change: discharge only off the 10/11 pair, switches dark meanwhile
    task automatic go(input logic [2:0] c, input logic [1:0] p);
        logic seen, clash;
        seen = 1'b0;
        clash = 1'b0;
        wr(UPMD_ADDR_CTRL, {29'h0, c}, UPMD_RESP_OK);
        repeat (16) begin
            @(negedge clk);
            seen = seen | dis;
            clash = clash | (dis & sw);
        end
        chk("discharge", {31'h0, p != c[1:0] && !(p[1] && c[1])}, {31'h0, seen});
        chk("sw_in_disch", 32'h0, {31'h0, clash});
        chk("outs", mode_outs(c[1:0], c[2]), outs_now);
        rd(UPMD_ADDR_STAT, 32'h900 | (32'h10 << c[1:0]) | c[1:0], UPMD_RESP_OK);
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wr(UPMD_ADDR_STAT, 32'hF, UPMD_RESP_ERR);
        wr(8'h10, 32'h7, UPMD_RESP_ERR);
        rd(8'h10, 32'h0, UPMD_RESP_ERR);
        rd(UPMD_ADDR_CTRL, UPMD_CTRL_RST, UPMD_RESP_OK);
        rd(UPMD_ADDR_MASK, UPMD_MASK_RST, UPMD_RESP_OK);
        rd(UPMD_ADDR_STAT, 32'h810, UPMD_RESP_OK);
        wr(UPMD_ADDR_MASK, 32'hFFFF_FFFF, UPMD_RESP_OK);
        rd(UPMD_ADDR_MASK, 32'hFFFF_FFFF, UPMD_RESP_OK);
        wr(UPMD_ADDR_MASK, 32'h0, UPMD_RESP_OK);
        pm = 2'h0;
        foreach (seq[i]) begin
            go(seq[i], pm);
            pm = seq[i][1:0];
        end
        // Enable low darkens the switches in charging mode
        wr(UPMD_ADDR_CTRL, 32'h3, UPMD_RESP_OK);
        repeat (4) @(negedge clk);
        chk("en_off", mode_outs(2'h3, 1'b0), outs_now);
        wr(UPMD_ADDR_CTRL, 32'h7, UPMD_RESP_OK);
        rd(UPMD_ADDR_IRQ, 32'h1, UPMD_RESP_OK);
        wr(UPMD_ADDR_MASK, 32'h2, UPMD_RESP_OK);
        @(posedge clk);
        lvl <= 2'h2;
        repeat (10) @(negedge clk);
        chk("load_early", 32'h0, {31'h0, ld});
        repeat (20) @(negedge clk);
        chk("load_on", 32'h3, {30'h0, ld, irq});
        rd(UPMD_ADDR_IRQ, 32'h2, UPMD_RESP_OK);
        @(negedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(UPMD_ADDR_MASK, 32'h0, UPMD_RESP_OK);
        @(posedge clk);
        lvl <= 2'h0;
        repeat (15) @(negedge clk);
        chk("load_hold", 32'h1, {31'h0, ld});
        repeat (30) @(negedge clk);
        chk("load_off", 32'h0, {30'h0, ld, irq});
        chk("cdp_sw", mode_outs(2'h3, 1'b1), outs_now);
        rd(UPMD_ADDR_IRQ, 32'h4, UPMD_RESP_OK);
        // Alternate mode ignores only the miscellaneous fault source
        wr(UPMD_ADDR_CTRL, 32'h6, UPMD_RESP_OK);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            flt <= 6'h01 << i;
            repeat (4) @(negedge clk);
            chk("fault_b", {31'h0, i == 0}, {31'h0, fault_b});
            @(posedge clk);
            flt <= 6'h00;
            repeat (4) @(negedge clk);
        end
        wr(UPMD_ADDR_CTRL, 32'h4, UPMD_RESP_OK);
        @(posedge clk);
        flt <= 6'h20;
        repeat (20) @(negedge clk);
        chk("client_fault_b", 32'h1, {31'h0, fault_b});
        give_verdict();
    end
endmodule
